// File: verilog/tec_pkg.sv
// Constants, field layout and carrier types of the 16-bit timer/event counter.
// Assumes a single clk_sys domain and a plain address/strobe register port.
package tec_pkg;

    // ----
    // Widths
    // ----
    localparam int CNT_W = 16; // Counter and capture/compare width
    localparam int ADDR_W = 4; // Register index width

    // ----
    // Register offsets (word index on the register port)
    // ----
    localparam logic [3:0] OFS_MODE_CTRL = 4'h0; // mode_control_register
    localparam logic [3:0] OFS_PRESC = 4'h1; // prescaler_mode_register
    localparam logic [3:0] OFS_CAP_CTRL = 4'h2; // Capture/compare role select
    localparam logic [3:0] OFS_CAPCMP_A = 4'h3; // capcmp_register_a
    localparam logic [3:0] OFS_CAPCMP_B = 4'h4; // capcmp_register_b
    localparam logic [3:0] OFS_COUNT = 4'h5; // main_count_value, read only
    localparam logic [3:0] OFS_STATUS = 4'h6; // Overflow and one-shot status

    // ----
    // Field positions
    // ----
    localparam int MC_OSP_EN = 0; // One-shot enable
    localparam int MC_OSP_TRIG = 1; // soft_oneshot_trigger, write-one pulse
    localparam int MC_OP_LOW = 2; // op_mode_bit_low
    localparam int MC_OP_HIGH = 3; // op_mode_bit_high
    localparam int PR_CLK_LO = 0; // Count clock divider select, 2 bits
    localparam int PR_EDGE_A_LO = 4; // edge_select_bit_low
    localparam int PR_EDGE_A_HI = 5; // edge_select_bit_high
    localparam int PR_EDGE_B_LO = 6; // Edge select of capture_pin_b, 2 bits
    localparam int CC_A_CAPTURE = 0; // Register a works as capture register
    localparam int CC_B_CAPTURE = 1; // Register b works as capture register
    localparam int ST_OVF = 0; // overflow_flag
    localparam int ST_OS_BUSY = 1; // One-shot pulse in progress

    // ----
    // Reset values
    // ----
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] RST_CAPCMP = 16'h0000;
    localparam logic [1:0] RST_EDGE = 2'h0;
    localparam logic [1:0] RST_CLK = 2'h0;
    localparam logic [2:0] RST_PRESC = 3'h0;

    // ----
    // Encodings
    // ----
    typedef enum logic [1:0] {
        OP_STOP = 2'h0, // Counter stopped, held at zero
        OP_PIN_CLR = 2'h1, // Clear and start on pin a valid edge
        OP_FREE = 2'h2, // Free running
        OP_MATCH_CLR = 2'h3 // Clear and start on match with register a
    } op_mode_e;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_e;

    typedef enum logic [2:0] {
        OS_IDLE = 3'b001, // No pulse in progress
        OS_WAIT = 3'b010, // Started, waiting for match with register b
        OS_HIGH = 3'b100 // Output high until match with register a
    } os_state_e;

    // ----
    // Register port request carrier
    // ----
    typedef struct packed {
        logic wr; // One-cycle write strobe
        logic rd; // One-cycle read strobe
        logic [ADDR_W-1:0] addr; // Register index
        logic [15:0] wdata; // Write data
    } reg_req_s;

endpackage

// File: verilog/tec_edge_detect.sv
// Valid-edge detector with two-sample noise filter for one input pin.
// Assumes the pin is synchronous to clk_sys.
`timescale 1ns/10ps

module tec_edge_detect (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pin,
    input wire tec_pkg::edge_sel_e edge_sel,
    input wire logic enable,
    output logic edge_pulse
);
    import tec_pkg::*;

    // ----
    // State
    // ----
    typedef struct packed {
        logic smp; // Previous pin sample
        logic lvl; // Filtered level, seen twice in a row
    } edge_s;

    edge_s st_ff; // Registered state
    edge_s nxt_st; // Next state
    logic stable; // Same level on two samples
    logic rise; // Filtered rising edge
    logic fall; // Filtered falling edge

    // Filter and edge selection; the level keeps tracking while disabled,
    // so a pin already high gives no rising edge on restart.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.smp = pin;
        stable = (pin == st_ff.smp);
        rise = stable && pin && !st_ff.lvl;
        fall = stable && !pin && st_ff.lvl;
        if (stable) begin
            nxt_st.lvl = pin;
        end
        unique case (edge_sel)
            EDGE_FALL: edge_pulse = enable && fall;
            EDGE_RISE: edge_pulse = enable && rise;
            EDGE_NONE: edge_pulse = 1'b0;
            EDGE_BOTH: edge_pulse = enable && (rise || fall);
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // tec_edge_detect

// File: verilog/tec_capcmp.sv
// One capture/compare register: software write, capture load, match.
// Assumes capture and write strobes are one-cycle pulses on clk_sys.
`timescale 1ns/10ps

module tec_capcmp #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    input wire logic cap_en,
    input wire logic [W-1:0] count,
    output logic [W-1:0] value,
    output logic match
);
    import tec_pkg::*;

    // Width must fit the 16-bit register port
    if (W < 2 || W > 16) begin : g_bad_w
        $error("tec_capcmp: W must lie in 2..16");
    end

    // ----
    // State
    // ----
    typedef struct packed {
        logic [W-1:0] val; // Stored value
    } cc_s;

    cc_s st_ff; // Registered state
    cc_s nxt_st; // Next state

    // Capture beats a software write in the same cycle
    always_comb begin
        nxt_st = st_ff;
        if (cap_en) begin
            nxt_st.val = count;
        end else if (wr_en) begin
            nxt_st.val = wdata;
        end
    end

    assign value = st_ff.val;
    assign match = (count == st_ff.val);

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '{val: RST_CAPCMP[W-1:0]};
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // tec_capcmp

// File: verilog/tec_timer.sv
// 16-bit timer/event counter with two capture/compare registers,
// overflow flag, pin valid-edge selection and one-shot pulse output.
// Assumes inputs synchronous to clk_sys and a one-cycle strobe port.
//
// Contract
// - Capture/compare contents undefined after counter stop.
// - Pin a edge select at prescaler bits 4,5.
// - Soft one-shot mode: pin a edge still restarts.
// - Overflow flag set on count FFFFH to 0000H.
// - Clearing overflow before count 0001H is void.
// - Capture beats concurrent read; read data undefined.
// - Reading counter never captures into register b.
// - Stopped counter ignores both pin inputs.
// - One-shot only in free-run and pin-clear modes.
// - Match-clear mode never produces a one-shot.
// - Nonzero operating mode starts counting at once.
`timescale 1ns/10ps

module tec_timer (
    input wire logic clk_sys,
    input wire logic srst,
    input wire tec_pkg::reg_req_s reg_req,
    output logic [15:0] reg_rdata,
    input wire logic trigger_capture_pin_a,
    input wire logic capture_pin_b,
    output logic oneshot_out
);
    import tec_pkg::*;

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] count; // main_count_value
        op_mode_e op_mode; // Operating mode bits
        logic osp_en; // One-shot enable
        edge_sel_e edge_a; // Pin a valid edge
        edge_sel_e edge_b; // Pin b valid edge
        logic [1:0] clk_sel; // Count clock divider select
        logic [2:0] presc; // Free prescaler counter
        logic cap_a; // Register a in capture role
        logic cap_b; // Register b in capture role
        logic ovf; // overflow_flag
        logic ovf_hold; // Overflow seen, count still 0000H
        os_state_e os_state; // One-shot sequencer
        logic pulse; // One-shot output level
        logic [15:0] rdata; // Read data, one cycle after strobe
    } tmr_s;

    tmr_s st_ff; // Registered state
    tmr_s nxt_st; // Next state

    logic running; // Operating mode is not stop
    logic tick; // Count clock enable
    logic edge_a; // Accepted valid edge on pin a
    logic edge_b; // Accepted valid edge on pin b
    logic [CNT_W-1:0] val_a; // capcmp_register_a
    logic [CNT_W-1:0] val_b; // capcmp_register_b
    logic match_a; // Count equals register a
    logic match_b; // Count equals register b
    logic wr_a; // Software write of register a
    logic wr_b; // Software write of register b
    logic cap_a_en; // Capture strobe into register a
    logic cap_b_en; // Capture strobe into register b
    logic sw_trig; // soft_oneshot_trigger written as one
    logic os_mode; // One-shot allowed in this mode
    logic os_trig; // One-shot start
    logic wrap; // Counter goes from all ones to zero
    logic ovf_set; // Hardware sets overflow_flag

    // -------------------------------------------------------------------
    // Pin edge detection
    // -------------------------------------------------------------------

    // Both pins are ignored while stopped
    assign running = (st_ff.op_mode != OP_STOP);

    tec_edge_detect u_edge_a (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin(trigger_capture_pin_a),
        .edge_sel(st_ff.edge_a),
        .enable(running),
        .edge_pulse(edge_a)
    );

    tec_edge_detect u_edge_b (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin(capture_pin_b),
        .edge_sel(st_ff.edge_b),
        .enable(running),
        .edge_pulse(edge_b)
    );

    // -------------------------------------------------------------------
    // Capture/compare registers
    // -------------------------------------------------------------------

    // Register a captures on pin b, register b on pin a; a counter read
    // plays no part in either capture.
    assign cap_a_en = st_ff.cap_a && edge_b;
    assign cap_b_en = st_ff.cap_b && edge_a;
    assign wr_a = reg_req.wr && (reg_req.addr == OFS_CAPCMP_A);
    assign wr_b = reg_req.wr && (reg_req.addr == OFS_CAPCMP_B);

    // Contents are left as they are on stop; software may not rely on them
    tec_capcmp #(
        .W(CNT_W)
    ) u_capcmp_a (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr_en(wr_a),
        .wdata(reg_req.wdata[CNT_W-1:0]),
        .cap_en(cap_a_en),
        .count(st_ff.count),
        .value(val_a),
        .match(match_a)
    );

    tec_capcmp #(
        .W(CNT_W)
    ) u_capcmp_b (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr_en(wr_b),
        .wdata(reg_req.wdata[CNT_W-1:0]),
        .cap_en(cap_b_en),
        .count(st_ff.count),
        .value(val_b),
        .match(match_b)
    );

    // -------------------------------------------------------------------
    // Count clock and triggers
    // -------------------------------------------------------------------

    // Divider select: 1, 2, 4 or 8 system clocks per count
    always_comb begin
        unique case (st_ff.clk_sel)
            2'h0: tick = running;
            2'h1: tick = running && (st_ff.presc[0] == 1'b1);
            2'h2: tick = running && (st_ff.presc[1:0] == 2'h3);
            2'h3: tick = running && (st_ff.presc == 3'h7);
        endcase
    end

    assign sw_trig = reg_req.wr && (reg_req.addr == OFS_MODE_CTRL)
        && reg_req.wdata[MC_OSP_TRIG];
    // Only free-run and pin-clear modes allow the one-shot; match-clear is refused
    assign os_mode = (st_ff.op_mode == OP_FREE)
        || (st_ff.op_mode == OP_PIN_CLR);
    // Pin a stays live even when the pulse is started by software
    assign os_trig = st_ff.osp_en && os_mode && (sw_trig || edge_a);
    // Match-clear with register a at all ones still wraps to zero
    assign wrap = tick && (st_ff.count == {CNT_W{1'b1}});
    // A clear while the count still sits at zero is overridden
    assign ovf_set = wrap || (st_ff.ovf_hold && st_ff.count == '0);

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------

    // Counter, control writes, flags, one-shot and read data
    always_comb begin
        nxt_st = st_ff;
        nxt_st.presc = st_ff.presc + 3'h1;
        nxt_st.rdata = 16'h0000;

        // Counter: held at zero when stopped, else counts per tick
        if (!running) begin
            nxt_st.count = RST_CNT[CNT_W-1:0];
        end else if (os_trig) begin
            nxt_st.count = '0;
        end else if (st_ff.op_mode == OP_PIN_CLR && edge_a) begin
            nxt_st.count = '0;
        end else if (tick) begin
            if (st_ff.op_mode == OP_MATCH_CLR && match_a) begin
                nxt_st.count = '0;
            end else begin
                nxt_st.count = st_ff.count + 1'b1;
            end
        end

        // Overflow hold lasts until the next count clock
        if (wrap) begin
            nxt_st.ovf_hold = 1'b1;
        end else if (tick || !running) begin
            nxt_st.ovf_hold = 1'b0;
        end

        // Software writes
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                OFS_MODE_CTRL: begin
                    // Any nonzero mode starts counting at the next edge
                    nxt_st.op_mode = op_mode_e'(
                        reg_req.wdata[MC_OP_HIGH:MC_OP_LOW]);
                    nxt_st.osp_en = reg_req.wdata[MC_OSP_EN];
                end
                OFS_PRESC: begin
                    nxt_st.clk_sel = reg_req.wdata[PR_CLK_LO+1:PR_CLK_LO];
                    // Edge selects only take a write while stopped
                    if (!running) begin
                        nxt_st.edge_a = edge_sel_e'(
                            reg_req.wdata[PR_EDGE_A_HI:PR_EDGE_A_LO]);
                        nxt_st.edge_b = edge_sel_e'(
                            reg_req.wdata[PR_EDGE_B_LO+1:PR_EDGE_B_LO]);
                    end
                end
                OFS_CAP_CTRL: begin
                    nxt_st.cap_a = reg_req.wdata[CC_A_CAPTURE];
                    nxt_st.cap_b = reg_req.wdata[CC_B_CAPTURE];
                end
                OFS_STATUS: begin
                    if (!reg_req.wdata[ST_OVF]) begin
                        nxt_st.ovf = 1'b0;
                    end
                end
                default: begin
                    // Count and unmapped indexes ignore writes
                end
            endcase
        end
        // Hardware set wins over a software clear
        if (ovf_set) begin
            nxt_st.ovf = 1'b1;
        end

        // One-shot sequencer; a new trigger restarts the count, so
        // overlapping triggers are the software's and partner's to avoid
        unique case (st_ff.os_state)
            OS_IDLE: begin
                if (os_trig) begin
                    nxt_st.os_state = OS_WAIT;
                end
            end
            OS_WAIT: begin
                if (!os_mode || !st_ff.osp_en) begin
                    nxt_st.os_state = OS_IDLE;
                end else if (os_trig) begin
                    nxt_st.os_state = OS_WAIT;
                end else if (tick && match_b) begin
                    nxt_st.os_state = OS_HIGH;
                    nxt_st.pulse = 1'b1;
                end
            end
            OS_HIGH: begin
                if (!os_mode || !st_ff.osp_en || (tick && match_a)) begin
                    nxt_st.os_state = OS_IDLE;
                    nxt_st.pulse = 1'b0;
                end
            end
            default: begin
                nxt_st.os_state = OS_IDLE;
                nxt_st.pulse = 1'b0;
            end
        endcase

        // Read mux; a capture in the same cycle leaves the read undefined
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_MODE_CTRL: begin
                    nxt_st.rdata[MC_OP_HIGH:MC_OP_LOW] = st_ff.op_mode;
                    nxt_st.rdata[MC_OSP_EN] = st_ff.osp_en;
                end
                OFS_PRESC: begin
                    nxt_st.rdata[PR_CLK_LO+1:PR_CLK_LO] = st_ff.clk_sel;
                    nxt_st.rdata[PR_EDGE_A_HI:PR_EDGE_A_LO] = st_ff.edge_a;
                    nxt_st.rdata[PR_EDGE_B_LO+1:PR_EDGE_B_LO] = st_ff.edge_b;
                end
                OFS_CAP_CTRL: begin
                    nxt_st.rdata[CC_A_CAPTURE] = st_ff.cap_a;
                    nxt_st.rdata[CC_B_CAPTURE] = st_ff.cap_b;
                end
                OFS_CAPCMP_A: nxt_st.rdata[CNT_W-1:0] = val_a;
                OFS_CAPCMP_B: nxt_st.rdata[CNT_W-1:0] = val_b;
                OFS_COUNT: nxt_st.rdata[CNT_W-1:0] = st_ff.count;
                OFS_STATUS: begin
                    nxt_st.rdata[ST_OVF] = st_ff.ovf;
                    nxt_st.rdata[ST_OS_BUSY] = (st_ff.os_state != OS_IDLE);
                end
                default: begin
                    // Unmapped indexes read as zero
                end
            endcase
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign oneshot_out = st_ff.pulse;

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------

    // Synchronous reset to a stopped counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '{
                count: RST_CNT[CNT_W-1:0],
                op_mode: OP_STOP,
                osp_en: 1'b0,
                edge_a: edge_sel_e'(RST_EDGE),
                edge_b: edge_sel_e'(RST_EDGE),
                clk_sel: RST_CLK,
                presc: RST_PRESC,
                cap_a: 1'b0,
                cap_b: 1'b0,
                ovf: 1'b0,
                ovf_hold: 1'b0,
                os_state: OS_IDLE,
                pulse: 1'b0,
                rdata: 16'h0000
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // tec_timer

// File: tb/tec_timer_props.sv
// Port checker of tec_timer, attached by bind.
// Assumes one clk_sys domain and the one-cycle strobe register port.
`timescale 1ns/10ps

module tec_timer_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire tec_pkg::reg_req_s reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic trigger_capture_pin_a,
    input wire logic capture_pin_b,
    input wire logic oneshot_out
);
    import tec_pkg::*;
    // ----
    // Shadow of mode and divider writes
    // ----
    typedef struct packed {
        logic [1:0] mode; // Op mode last written
        logic osp; // One-shot enable last written
        logic [1:0] clk; // Divider select last written
        logic [1:0] quiet; // Cycles since a config write, saturating
    } shadow_s;
    shadow_s sh_ff, nxt_sh;
    // Quiet margin hides the start-up latency of a mode change
    wire logic free_run = sh_ff.mode == 2'h2 && !sh_ff.osp && sh_ff.clk == 2'h0
        && sh_ff.quiet == 2'h3;
    wire logic stopped = sh_ff.mode == 2'h0 && sh_ff.quiet == 2'h3;
    wire logic rd_cnt = reg_req.rd && reg_req.addr == OFS_COUNT;
    wire logic rd_b = reg_req.rd && reg_req.addr == OFS_CAPCMP_B;
    // Next shadow from the write strobe
    always_comb begin
        nxt_sh = sh_ff;
        if (sh_ff.quiet != 2'h3) nxt_sh.quiet = sh_ff.quiet + 2'h1;
        if (reg_req.wr && reg_req.addr == OFS_MODE_CTRL) begin
            nxt_sh.mode = reg_req.wdata[MC_OP_HIGH:MC_OP_LOW];
            nxt_sh.osp = reg_req.wdata[MC_OSP_EN];
            nxt_sh.quiet = 2'h0;
        end
        if (reg_req.wr && reg_req.addr == OFS_PRESC) begin
            nxt_sh.clk = reg_req.wdata[1:0];
            nxt_sh.quiet = 2'h0;
        end
    end
    // Shadow register
    always_ff @(posedge clk_sys) begin
        if (srst) sh_ff <= '0;
        else sh_ff <= nxt_sh;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ----
    // Sequences and assertions
    // ----
    sequence start_free;
        reg_req.wr && reg_req.addr == OFS_MODE_CTRL && reg_req.wdata[3:0] == 4'h8
            && sh_ff.mode == 2'h0 && sh_ff.clk == 2'h0;
    endsequence
    sequence two_count_reads;
        (rd_cnt && free_run) ##1 rd_cnt;
    endsequence
    sequence two_b_reads;
        (rd_b && stopped) ##1 (rd_b && stopped);
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) srst |=> reg_rdata == 16'h0
        && !oneshot_out) else $error("outputs not cleared by reset");
    rdata_idle_a: assert property (!reg_req.rd |=> reg_rdata == 16'h0)
        else $error("stray read data");
    stop_zero_a: assert property (rd_cnt && stopped |=> reg_rdata == 16'h0)
        else $error("stopped counter not zero");
    count_step_a: assert property (two_count_reads |=> reg_rdata == $past(reg_rdata) + 16'h1)
        else $error("counter step not one");
    run_start_a: assert property (start_free ##1 (!reg_req.wr)[*5] ##0 rd_cnt
        |=> reg_rdata != 16'h0) else $error("counter did not start");
    pin_ignore_a: assert property (two_b_reads |=> reg_rdata == $past(reg_rdata))
        else $error("capture while stopped");
    mode3_quiet_a: assert property (sh_ff.mode == 2'h3 && sh_ff.quiet == 2'h3
        |-> !oneshot_out) else $error("one-shot in match-clear mode");
    status_upper_a: assert property (reg_req.rd && reg_req.addr == OFS_STATUS
        |=> reg_rdata[15:2] == 14'h0) else $error("status upper bits set");
endmodule // tec_timer_props

bind tec_timer tec_timer_props tec_timer_props_i (.clk_sys(clk_sys), .srst(srst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .trigger_capture_pin_a(trigger_capture_pin_a),
    .capture_pin_b(capture_pin_b), .oneshot_out(oneshot_out));

// File: tb/tec_pin_model.sv
// Model of the external trigger and capture source on both pins.
// Assumes one bench process calls its task at a time.
`timescale 1ns/10ps

module tec_pin_model (
    input wire logic clk_sys,
    output logic pin_a,
    output logic pin_b
);
    // Pins idle low after power-up
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // New levels after an edge, held steady so the filter sees them at least twice
    task automatic set_pins(input logic a, input logic b, input int hold);
        @(posedge clk_sys);
        pin_a <= a;
        pin_b <= b;
        repeat (hold) @(posedge clk_sys);
    endtask
endmodule // tec_pin_model

// File: tb/tec_timer_tb.sv
// Self-checking bench of tec_timer: queue of read notes, pin model.
// Assumes tec_pkg, the design and the pin model are compiled first.
`timescale 1ns/10ps

`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end

module tec_timer_tb;
    import tec_pkg::*;
    typedef struct packed {
        logic chk; // Compare this answer
        logic [15:0] exp; // Expected read data
    } note_s;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    reg_req_s reg_req = '0;
    logic [15:0] reg_rdata, last_rd, prev_rd, rnd;
    logic pin_a, pin_b, oneshot_out;
    logic rd_d = 1'b0;
    note_s notes[$];
    note_s nt;
    int errors = 0;
    int checks_done = 0;
    int w;

    always #2.5 clk_sys = ~clk_sys;

    tec_timer tec_timer_i (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .trigger_capture_pin_a(pin_a), .capture_pin_b(pin_b),
        .oneshot_out(oneshot_out));
    tec_pin_model tec_pin_model_i (.clk_sys(clk_sys), .pin_a(pin_a), .pin_b(pin_b));

    // Answer watcher: oldest note against each read answer
    always @(posedge clk_sys) begin
        if (rd_d) begin
            nt = notes.pop_front();
            prev_rd = last_rd;
            last_rd = reg_rdata;
            if (nt.chk) `CHK(reg_rdata, nt.exp)
        end
        rd_d <= reg_req.rd;
    end
    // ----
    // Bus tasks
    // ----
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask
    // n back-to-back reads; returns once the last answer is taken
    task automatic reg_read(input logic [3:0] a, input logic c, input logic [15:0] e,
        input int n);
        repeat (n) notes.push_back('{c, e});
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
        repeat (n) @(posedge clk_sys);
        reg_req <= '0;
        @(posedge clk_sys);
        #1;
    endtask
    // Poll a register until masked value matches, bounded
    task automatic wait_val(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        int k;
        for (k = 0; k < 300; k++) begin
            reg_read(a, 1'b0, 16'h0, 1);
            if ((last_rd & m) == e) break;
        end
        `CHK(k < 300, 1'b1)
    endtask
    task automatic pulse_width(output int n);
        n = 0;
        repeat (40) begin
            @(posedge clk_sys);
            if (oneshot_out === 1'b1) n++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog sized above the long overflow wait
    initial begin
        repeat (90000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
    // ----
    // Tests
    // ----
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        void'($urandom(32'hc1c01b39));
        rnd = $urandom;
        for (int i = 0; i < 8; i++) reg_read(i[3:0], 1'b1, 16'h0, 1);
        reg_write(OFS_CAPCMP_B, rnd);
        reg_write(OFS_COUNT, ~rnd);
        reg_read(OFS_CAPCMP_B, 1'b1, rnd, 1);
        reg_read(OFS_COUNT, 1'b1, 16'h0, 1);
        $display("test registers done");
        reg_write(OFS_MODE_CTRL, 16'h0000);
        reg_write(OFS_PRESC, 16'h0010);
        reg_write(OFS_CAP_CTRL, 16'h0002);
        tec_pin_model_i.set_pins(1'b1, 1'b1, 4);
        reg_read(OFS_CAPCMP_B, 1'b1, rnd, 2);
        reg_write(OFS_MODE_CTRL, 16'h0008);
        repeat (3) @(posedge clk_sys);
        reg_read(OFS_COUNT, 1'b0, 16'h0, 2);
        `CHK(last_rd, prev_rd + 16'h1)
        reg_read(OFS_CAPCMP_B, 1'b1, rnd, 1);
        tec_pin_model_i.set_pins(1'b0, 1'b0, 4);
        reg_read(OFS_CAPCMP_B, 1'b1, rnd, 1);
        tec_pin_model_i.set_pins(1'b1, 1'b0, 4);
        reg_read(OFS_COUNT, 1'b0, 16'h0, 1);
        reg_read(OFS_CAPCMP_B, 1'b0, 16'h0, 1);
        `CHK((prev_rd - last_rd) inside {[16'h1 : 16'hc]}, 1'b1)
        $display("test capture done");
        reg_write(OFS_MODE_CTRL, 16'h0000);
        reg_write(OFS_CAP_CTRL, 16'h0000);
        reg_write(OFS_CAPCMP_A, 16'h0005);
        reg_write(OFS_CAPCMP_B, 16'h0002);
        tec_pin_model_i.set_pins(1'b0, 1'b0, 4);
        reg_write(OFS_MODE_CTRL, 16'h0009);
        reg_write(OFS_MODE_CTRL, 16'h000b);
        pulse_width(w);
        `CHK(w, 3)
        reg_read(OFS_STATUS, 1'b1, 16'h0, 1);
        reg_write(OFS_MODE_CTRL, 16'h0005);
        tec_pin_model_i.set_pins(1'b1, 1'b0, 0);
        pulse_width(w);
        `CHK(w, 3)
        reg_write(OFS_MODE_CTRL, 16'h000f);
        pulse_width(w);
        `CHK(w, 0)
        $display("test one-shot done");
        reg_write(OFS_MODE_CTRL, 16'h0000);
        reg_write(OFS_PRESC, 16'h0000);
        reg_write(OFS_CAPCMP_A, 16'hffff);
        reg_write(OFS_MODE_CTRL, 16'h0008);
        repeat (65440) @(posedge clk_sys);
        wait_val(OFS_COUNT, 16'hfff0, 16'hfff0);
        reg_read(OFS_STATUS, 1'b1, 16'h0, 1);
        reg_write(OFS_PRESC, 16'h0003);
        wait_val(OFS_STATUS, 16'h0001, 16'h0001);
        reg_write(OFS_STATUS, 16'h0000);
        reg_read(OFS_STATUS, 1'b1, 16'h0001, 1);
        wait_val(OFS_COUNT, 16'hffff, 16'h0002);
        reg_write(OFS_STATUS, 16'h0000);
        reg_read(OFS_STATUS, 1'b1, 16'h0000, 1);
        $display("test overflow done");
        give_verdict();
    end
endmodule // tec_timer_tb
